// file: frame_bus_if.sv
`timescale 1ns/1ps
// Decoded serial frame events passed from the shifter to the command logic.
interface frame_bus_if;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic tx_load;
  logic frame_active;
  logic frame_end;
  logic hold;
  modport shifter(output byte_done, output rx_byte, output frame_active, output frame_end,
    input tx_byte, input tx_load, input hold);
  modport control(input byte_done, input rx_byte, input frame_active, input frame_end,
    output tx_byte, output tx_load, output hold);
endinterface

// file: serial_shifter.sv
`timescale 1ns/1ps
// =====================================================================
// Serial shifter: samples the link pins and assembles bytes.
module serial_shifter
  import spi_port_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic resetn,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Frame events
  frame_bus_if.shifter fb
);
  logic [1:0] sclk_sync_reg, cs_sync_reg, sdi_sync_reg;
  logic sclk_prev_reg, cs_prev_reg;
  logic [7:0] shift_reg, shift_next, out_reg, out_next;
  logic [2:0] bit_reg, bit_next;
  logic sdo_reg, sdo_next, done_reg, done_next;
  logic fall, rise, active;

  always_ff @(posedge clock)
  begin
    sclk_sync_reg <= {sclk_sync_reg[0], sclk};
    cs_sync_reg <= {cs_sync_reg[0], cs_n};
    sdi_sync_reg <= {sdi_sync_reg[0], sdi};
    sclk_prev_reg <= sclk_sync_reg[1];
    cs_prev_reg <= cs_sync_reg[1];
  end

  assign active = !cs_sync_reg[1];
  assign fall = sclk_prev_reg && !sclk_sync_reg[1];
  assign rise = !sclk_prev_reg && sclk_sync_reg[1];
  assign fb.frame_active = active;
  assign fb.frame_end = !cs_prev_reg && cs_sync_reg[1];
  assign fb.byte_done = done_reg;
  assign fb.rx_byte = shift_reg;

  always_comb
  begin
    shift_next = shift_reg;
    bit_next = bit_reg;
    out_next = out_reg;
    sdo_next = sdo_reg;
    done_next = 1'b0;
    if (!active || fb.hold)
    begin
      bit_next = 3'h0;
    end
    else
    begin
      if (fb.tx_load)
        out_next = fb.tx_byte;
      if (fall)
      begin
        shift_next = {shift_reg[6:0], sdi_sync_reg[1]};
        bit_next = bit_reg + 3'h1;
        done_next = (bit_reg == 3'h7);
      end
      if (rise)
      begin
        sdo_next = out_reg[7];
        out_next = {out_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      shift_reg <= ZERO_BYTE;
      bit_reg <= 3'h0;
      out_reg <= ZERO_BYTE;
      sdo_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      out_reg <= out_next;
      sdo_reg <= sdo_next;
      done_reg <= done_next;
    end
  end

  assign sdo = sdo_reg;
  // Released outside a frame and while a forwarded select owns the bus.
  assign sdo_oe = active && !fb.hold;
endmodule // serial_shifter

// file: spi_command_port.sv
`timescale 1ns/1ps
// How it works
// - Write: command 01T0 plus pointer, then one data byte stored in register.
// - Read: 1000 plus pointer; data shifts out next byte; never triggers buffer.
// - Command 11T0 0ccc asserts forwarded select on pin ccc if enabled.
// - Trigger bit 5 set starts the buffer, except on reads, reserved commands and checksum mismatches.
// - With checksum on, writes decode only after the third byte.
// - Reads append a checksum byte when master clocks eight more bits after the data byte.
// - Checksum mismatch with mode on discards write and sets error flag.
// - Checksum is eight-bit sum seeded with 9b, command then data.
// - Read checksum: master sends seed+command; device returns seed+command+data.
// - Select command has no data byte; checksum is seed plus command.
// - Checksum accumulates across chained commands within one select period.
// - Active forwarded select ignores link until own select rises.
// - Direction bits 0 to 6 map to pins; 1 is output.
// - Forwarded select output needs both enable and direction bits set.
// - Special function beats select enable, which beats plain pin use.
// - Clock-phase bit picks which serial clock edge follows select assertion.
// - Multiplexer special functions drive pins 0 to 2 from gain register.
// - Pin 3 error output equals the OR of source error bits whose enable bit is clear.
// - Pin 4 rising edge starts buffer four cycles after its synchronised edge, held while high.
// - Pin data bits drive inverted: one gives low.
// - Select active low; data sampled on falling serial clock edge.
// - Power-on and software reset both disable checksum mode.
// - Serial data output floats while a forwarded select is asserted.
module spi_command_port
  import spi_port_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic resetn,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Multi-function pins
  input wire logic [spi_port_pkg::PIN_COUNT-1:0] pin_in,
  output logic [spi_port_pkg::PIN_COUNT-1:0] pin_out,
  output logic [spi_port_pkg::PIN_COUNT-1:0] pin_oe,
  // Analog side
  input wire logic [7:0] error_sources,
  input wire logic buffer_busy,
  output logic buffer_start,
  output logic buffer_pin_hold,
  output logic [7:0] gain_setting
);
  import spi_port_pkg::*;

  // ===================================================================
  // Types and helpers
  typedef enum logic [4:0]
  {
    ST_CMD = 5'b00001,
    ST_DATA = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_TAIL = 5'b01000,
    ST_FORWARD = 5'b10000
  } cmd_state_t;

  function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction

  frame_bus_if fb();

  serial_shifter shifter_u
  (
    .clock(clock),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .fb(fb)
  );

  // ===================================================================
  // Pin input synchronisers
  logic [PIN_COUNT-1:0] pin_s1_reg, pin_s2_reg;
  logic trig_prev_reg;
  always_ff @(posedge clock)
  begin
    pin_s1_reg <= pin_in;
    pin_s2_reg <= pin_s1_reg;
    trig_prev_reg <= pin_s2_reg[FUNC_TRIGGER_PIN];
  end

  // ===================================================================
  // Command state
  cmd_state_t state_reg, state_next;
  logic [7:0] cmd_reg, cmd_next, data_reg, data_next, sum_reg, sum_next;
  logic [7:0] tx_reg, tx_next;
  logic load_reg, load_next, hold_reg, hold_next;
  logic [2:0] fwd_pin_reg, fwd_pin_next;
  logic [7:0] gain_reg, clock_phase_reg, buffer_time_reg, error_flags_reg;
  logic [7:0] pin_data_reg, pin_dir_reg, select_en_reg, error_en_reg;
  logic [7:0] port_config_reg, special_reg;
  logic do_write, do_trigger, write_ok;
  logic [7:0] wr_data, rd_data;
  logic [3:0] wr_addr;
  logic soft_reset;
  logic checksum_on;

  assign checksum_on = port_config_reg[CHECKSUM_MODE_BIT];

  function automatic logic [7:0] read_reg(input logic [3:0] a);
    case (a)
      ADDR_GAIN: return gain_reg;
      ADDR_CLOCK_PHASE: return clock_phase_reg;
      ADDR_BUFFER_TIME: return buffer_time_reg;
      ADDR_ERROR_FLAGS: return error_flags_reg;
      ADDR_PIN_DATA: return pin_data_reg;
      ADDR_PIN_DIR: return pin_dir_reg;
      ADDR_SELECT_EN: return select_en_reg;
      ADDR_ERROR_EN: return error_en_reg;
      ADDR_PORT_CONFIG: return port_config_reg;
      ADDR_SPECIAL: return special_reg;
      default: return ZERO_BYTE;
    endcase
  endfunction

  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    sum_next = sum_reg;
    tx_next = tx_reg;
    load_next = 1'b0;
    hold_next = hold_reg;
    fwd_pin_next = fwd_pin_reg;
    do_write = 1'b0;
    do_trigger = 1'b0;
    write_ok = 1'b0;
    wr_addr = cmd_reg[3:0];
    wr_data = data_reg;
    rd_data = read_reg(cmd_reg[3:0]);
    if (!fb.frame_active)
    begin
      state_next = ST_CMD;
      sum_next = CHECKSUM_SEED;
      hold_next = 1'b0;
    end
    else if (fb.byte_done)
    begin
      case (state_reg)
        ST_CMD:
        begin
          cmd_next = fb.rx_byte;
          sum_next = sum8(sum_reg, fb.rx_byte);
          case (fb.rx_byte[7:6])
            CMD_READ:
            begin
              tx_next = read_reg(fb.rx_byte[3:0]);
              load_next = 1'b1;
              state_next = ST_DATA;
            end
            CMD_WRITE:
              state_next = ST_DATA;
            CMD_SELECT:
            begin
              fwd_pin_next = fb.rx_byte[2:0];
              if (checksum_on)
                state_next = ST_CHECK;
              else
              begin
                state_next = ST_FORWARD;
                do_trigger = fb.rx_byte[TRIGGER_BIT];
                hold_next = select_en_reg[fb.rx_byte[2:0]] &&
                  pin_dir_reg[fb.rx_byte[2:0]] && (fb.rx_byte[2:0] <= LAST_PIN);
              end
            end
            default:
              state_next = ST_TAIL;
          endcase
        end
        ST_DATA:
        begin
          data_next = fb.rx_byte;
          if (cmd_reg[7:6] == CMD_READ)
          begin
            tx_next = sum8(sum_reg, rd_data);
            sum_next = sum8(sum_reg, rd_data);
            load_next = 1'b1;
            state_next = ST_TAIL;
          end
          else
          begin
            sum_next = sum8(sum_reg, fb.rx_byte);
            if (checksum_on)
              state_next = ST_CHECK;
            else
            begin
              do_write = 1'b1;
              wr_data = fb.rx_byte;
              do_trigger = cmd_reg[TRIGGER_BIT];
              state_next = ST_TAIL;
            end
          end
        end
        ST_CHECK:
        begin
          state_next = ST_CMD;
          if (fb.rx_byte == sum_reg)
          begin
            do_trigger = cmd_reg[TRIGGER_BIT];
            if (cmd_reg[7:6] == CMD_SELECT)
            begin
              state_next = ST_FORWARD;
              hold_next = select_en_reg[fwd_pin_reg] && pin_dir_reg[fwd_pin_reg] &&
                (fwd_pin_reg <= LAST_PIN);
            end
            else
              do_write = 1'b1;
          end
          else
            write_ok = 1'b1; // Mismatch: flagged below.
        end
        ST_TAIL:
          state_next = ST_CMD;
        default:
          state_next = ST_FORWARD;
      endcase
    end
  end

  assign soft_reset = do_write && (wr_addr == ADDR_SWRESET) && wr_data[0];

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_reg <= ST_CMD;
      cmd_reg <= ZERO_BYTE;
      data_reg <= ZERO_BYTE;
      sum_reg <= CHECKSUM_SEED;
      tx_reg <= ZERO_BYTE;
      load_reg <= 1'b0;
      hold_reg <= 1'b0;
      fwd_pin_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      sum_reg <= sum_next;
      tx_reg <= tx_next;
      load_reg <= load_next;
      hold_reg <= hold_next;
      fwd_pin_reg <= fwd_pin_next;
    end
  end

  assign fb.tx_byte = tx_reg;
  assign fb.tx_load = load_reg;
  assign fb.hold = hold_reg;

  // ===================================================================
  // Register file
  logic [7:0] gain_next, clock_phase_next, buffer_time_next, error_flags_next;
  logic [7:0] pin_data_next, pin_dir_next, select_en_next, error_en_next;
  logic [7:0] port_config_next, special_next;
  logic [7:0] raised;

  always_comb
  begin
    gain_next = gain_reg;
    clock_phase_next = clock_phase_reg;
    buffer_time_next = buffer_time_reg;
    pin_data_next = pin_data_reg;
    pin_dir_next = pin_dir_reg;
    select_en_next = select_en_reg;
    error_en_next = error_en_reg;
    port_config_next = port_config_reg;
    special_next = special_reg;
    error_flags_next = error_flags_reg;
    if (do_write)
    begin
      case (wr_addr)
        ADDR_GAIN: gain_next = wr_data;
        ADDR_CLOCK_PHASE: clock_phase_next = {1'b0, wr_data[6:0]};
        ADDR_BUFFER_TIME: buffer_time_next = wr_data;
        ADDR_ERROR_FLAGS: error_flags_next = error_flags_reg & ~wr_data;
        ADDR_PIN_DATA: pin_data_next = {1'b0, wr_data[6:0]};
        ADDR_PIN_DIR: pin_dir_next = {1'b0, wr_data[6:0]};
        ADDR_SELECT_EN: select_en_next = {1'b0, wr_data[6:0]};
        ADDR_ERROR_EN: error_en_next = wr_data;
        ADDR_PORT_CONFIG: port_config_next = wr_data;
        ADDR_SPECIAL: special_next = wr_data;
        default: ;
      endcase
    end
    // Hardware events win over a clearing write in the same cycle.
    raised = error_sources & ERROR_SOURCE_MASK;
    raised[CHECKSUM_ERROR_BIT] = write_ok && checksum_on;
    error_flags_next = (error_flags_next | raised) & ERROR_SOURCE_MASK
      | (error_flags_next & (8'h01 << CHECKSUM_ERROR_BIT)) | raised;
    error_flags_next[BUFFER_ACTIVE_BIT] = buffer_busy;
    error_flags_next[ERROR_OUT_BIT] =
      |(error_flags_next & ERROR_SOURCE_MASK & ~error_en_reg);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn || soft_reset)
    begin
      gain_reg <= ZERO_BYTE;
      clock_phase_reg <= ZERO_BYTE;
      buffer_time_reg <= BUFFER_TIME_RESET;
      error_flags_reg <= ZERO_BYTE;
      pin_data_reg <= ZERO_BYTE;
      pin_dir_reg <= ZERO_BYTE;
      select_en_reg <= ZERO_BYTE;
      error_en_reg <= ZERO_BYTE;
      port_config_reg <= ZERO_BYTE;
      special_reg <= ZERO_BYTE;
    end
    else
    begin
      gain_reg <= gain_next;
      clock_phase_reg <= clock_phase_next;
      buffer_time_reg <= buffer_time_next;
      error_flags_reg <= error_flags_next;
      pin_data_reg <= pin_data_next;
      pin_dir_reg <= pin_dir_next;
      select_en_reg <= select_en_next;
      error_en_reg <= error_en_next;
      port_config_reg <= port_config_next;
      special_reg <= special_next;
    end
  end

  // ===================================================================
  // Buffer trigger from command bit and pin 4
  logic [TRIGGER_DELAY-1:0] trig_pipe_reg, trig_pipe_next;
  logic start_reg, start_next;
  always_comb
  begin
    trig_pipe_next = {trig_pipe_reg[TRIGGER_DELAY-2:0],
      special_reg[FUNC_TRIGGER_PIN] && !pin_dir_reg[FUNC_TRIGGER_PIN] &&
      pin_s2_reg[FUNC_TRIGGER_PIN] && !trig_prev_reg};
    start_next = do_trigger || trig_pipe_reg[TRIGGER_DELAY-1];
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      trig_pipe_reg <= '0;
      start_reg <= 1'b0;
    end
    else
    begin
      trig_pipe_reg <= trig_pipe_next;
      start_reg <= start_next;
    end
  end
  assign buffer_start = start_reg;
  // The analog timer extends the active time while this stays high.
  assign buffer_pin_hold = special_reg[FUNC_TRIGGER_PIN] && pin_s2_reg[FUNC_TRIGGER_PIN];
  assign gain_setting = gain_reg;

  // ===================================================================
  // Pin function selection
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      pin_oe[i] = pin_dir_reg[i];
      pin_out[i] = !pin_data_reg[i];
      if (special_reg[i])
      begin
        if (i < ERROR_OUT_BIT)
          pin_out[i] = gain_reg[i];
        else if (i == FUNC_ERROR_PIN)
          pin_out[i] = error_flags_reg[ERROR_OUT_BIT];
        else if (i == FUNC_BUFFER_PIN)
          pin_out[i] = buffer_busy ^ error_en_reg[BUFFER_POLARITY_BIT];
        else
          pin_out[i] = 1'b0;
      end
      else if (select_en_reg[i] && pin_dir_reg[i])
      begin
        // Phase bit only shapes the master's clock; select drops right after command, or after its check byte with checksum on.
        pin_out[i] = !(hold_reg && fwd_pin_reg == 3'(i));
      end
    end
  end

  // ===================================================================
  // Checks
  read_no_trigger_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_reg == ST_CMD && fb.byte_done && fb.rx_byte[7:6] == CMD_READ) |-> ##1 !buffer_start)
    else $error("read triggered buffer");
  forward_sdo_off_a: assert property (@(posedge clock) disable iff (!resetn)
    hold_reg |-> !sdo_oe) else $error("sdo driven during forward");
  reserved_noop_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_reg == ST_TAIL) |-> !do_write) else $error("write in tail");
  bad_check_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    (write_ok && checksum_on) |-> ##1 error_flags_reg[CHECKSUM_ERROR_BIT])
    else $error("checksum error not flagged");
  frame_end_release_a: assert property (@(posedge clock) disable iff (!resetn)
    !fb.frame_active |-> ##1 !hold_reg) else $error("select held after frame");
  pin_invert_a: assert property (@(posedge clock) disable iff (!resetn)
    (special_reg[0] == 1'b0 && select_en_reg[0] == 1'b0) |-> pin_out[0] == !pin_data_reg[0])
    else $error("pin data not inverted");
  mux_pin_a: assert property (@(posedge clock) disable iff (!resetn)
    special_reg[1] |-> pin_out[1] == gain_reg[1]) else $error("mux pin wrong");
  pin_trigger_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(trig_pipe_reg[0]) |-> ##3 buffer_start) else $error("pin trigger late");
endmodule // spi_command_port

// file: spi_master_model.sv
`timescale 1ns/1ps
// =====================================================================
// Serial master model: the link clock idles low, runs at 80 ns and stands still between frames.
module spi_master_model
(
  // System
  input wire logic clock,
  // Link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic last_sdo;
  logic sdo_line;
  // The line has no pull, so a released line shows the inverse of its last level.
  assign sdo_line = sdo_oe ? sdo : ~last_sdo;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    last_sdo = 1'b0;
  end
  always @(posedge clock)
    if (sdo_oe === 1'b1)
      last_sdo <= sdo;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic start();
    tick(1);
    cs_n = 1'b0;
    tick(5);
  endtask
  // Five system clocks per half period; data in moves together with the rising clock edge.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi = tx[i];
      sclk = 1'b1;
      tick(5);
      rx[i] = sdo_line;
      sclk = 1'b0;
      tick(5);
    end
  endtask
  task automatic stop();
    cs_n = 1'b1;
    tick(10);
  endtask
endmodule // spi_master_model

// file: spi_port_pkg.sv
package spi_port_pkg;
  // Register pointers.
  localparam logic [3:0] ADDR_GAIN = 4'h0;
  localparam logic [3:0] ADDR_SWRESET = 4'h1;
  localparam logic [3:0] ADDR_CLOCK_PHASE = 4'h2;
  localparam logic [3:0] ADDR_BUFFER_TIME = 4'h3;
  localparam logic [3:0] ADDR_ERROR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_PIN_DATA = 4'h5;
  localparam logic [3:0] ADDR_PIN_DIR = 4'h8;
  localparam logic [3:0] ADDR_SELECT_EN = 4'h9;
  localparam logic [3:0] ADDR_ERROR_EN = 4'ha;
  localparam logic [3:0] ADDR_PORT_CONFIG = 4'hb;
  localparam logic [3:0] ADDR_SPECIAL = 4'hc;
  // Command prefixes in bits 7:6 and the forwarded-select pin count.
  localparam logic [1:0] CMD_RESERVED = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_SELECT = 2'h3;
  localparam int TRIGGER_BIT = 5;
  localparam int PIN_COUNT = 7;
  localparam logic [2:0] LAST_PIN = 3'h6;
  // Checksum seed.
  localparam logic [7:0] CHECKSUM_SEED = 8'h9b;
  // Field positions.
  localparam int CHECKSUM_MODE_BIT = 0;
  localparam int CHECKSUM_ERROR_BIT = 7;
  localparam int BUFFER_ACTIVE_BIT = 5;
  localparam int ERROR_OUT_BIT = 3;
  localparam logic [7:0] ERROR_SOURCE_MASK = 8'h57;
  localparam int FUNC_ERROR_PIN = 3;
  localparam int FUNC_TRIGGER_PIN = 4;
  localparam int FUNC_BUFFER_PIN = 5;
  localparam int BUFFER_POLARITY_BIT = 5;
  // Reset values.
  localparam logic [7:0] BUFFER_TIME_RESET = 8'h19;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Trigger pin pipeline of three clock cycles; the start register adds a fourth.
  localparam int TRIGGER_DELAY = 3;
  localparam int BYTE_BITS = 8;
endpackage

// file: tb_spi_command_port_checksum_ecs.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the command port.
module tb_spi_command_port_checksum_ecs;
  import spi_port_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, buffer_start, buffer_pin_hold;
  logic [PIN_COUNT-1:0] pin_out, pin_oe;
  logic [PIN_COUNT-1:0] pin_in = 7'h00;
  logic [7:0] error_sources = 8'h00;
  logic buffer_busy = 1'b0;
  logic [7:0] gain_setting, d, s1, s2, r;
  logic [7:0] rxq[$];
  logic [7:0] ref_regs[16];
  logic [3:0] addrs[10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  int miscompares = 0;
  int num_checks = 0;
  int starts = 0;
  int st;
  always #4 clock = ~clock;
  always @(posedge clock)
    if (buffer_start === 1'b1)
      starts <= starts + 1;
  spi_command_port uut (.clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .error_sources(error_sources), .buffer_busy(buffer_busy), .buffer_start(buffer_start),
    .buffer_pin_hold(buffer_pin_hold), .gain_setting(gain_setting));
  spi_master_model m (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] q[$], input bit close);
    logic [7:0] b;
    rxq.delete();
    m.start();
    foreach (q[i])
    begin
      m.xbyte(q[i], b);
      rxq.push_back(b);
    end
    if (close)
      m.stop();
  endtask
  task automatic clear_ref();
    foreach (ref_regs[i])
      ref_regs[i] = ZERO_BYTE;
    ref_regs[ADDR_BUFFER_TIME] = BUFFER_TIME_RESET;
  endtask
  // Every frame ends with seed plus command plus data: a tail byte in plain mode, the check byte in checksum mode.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] c;
    c = {4'h4, a};
    send('{c, v, 8'(CHECKSUM_SEED + c + v)}, 1'b1);
    ref_regs[a] = v;
  endtask
  task automatic rd(input logic [3:0] a);
    logic [7:0] c;
    c = {4'h8, a};
    // Data rides on the byte after the command; in checksum mode that byte is seed plus command.
    if (ref_regs[ADDR_PORT_CONFIG][CHECKSUM_MODE_BIT])
      send('{c, 8'(CHECKSUM_SEED + c), 8'h00}, 1'b1);
    else
      send('{c, 8'h00, 8'h00}, 1'b1);
    check("read data", ref_regs[a], rxq[1]);
    check("read sum", 8'(CHECKSUM_SEED + c + ref_regs[a]), rxq[2]);
  endtask
  initial
  begin
    #500000;
    miscompares++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h5527b21d));
    clear_ref();
    repeat (12) @(posedge clock);
    #1 resetn = 1'b1;
    foreach (addrs[i])
      rd(addrs[i]);
    repeat (3)
    begin
      d = 8'($urandom);
      wr(ADDR_GAIN, d);
      check("gain", d, gain_setting);
      rd(ADDR_GAIN);
    end
    wr(ADDR_CLOCK_PHASE, 8'hff);
    ref_regs[ADDR_CLOCK_PHASE] = 8'h7f;
    rd(ADDR_CLOCK_PHASE);
    st = starts;
    send('{8'h20, 8'h5a}, 1'b1);
    rd(ADDR_GAIN);
    wr(ADDR_GAIN, 8'h11);
    send('{8'h60, 8'h11, 8'h00}, 1'b1);
    check("start count", 8'(st + 1), 8'(starts));
    rd(ADDR_GAIN);
    check("read start count", 8'(st + 1), 8'(starts));
    wr(ADDR_PIN_DIR, 8'h0f);
    wr(ADDR_PIN_DATA, 8'h05);
    check("pin enable", 8'h0f, {1'b0, pin_oe});
    check("pin level", 8'h0a, {4'h0, pin_out[3:0]});
    wr(ADDR_SPECIAL, 8'h07);
    check("mux pins", 8'h01, {5'h00, pin_out[2:0]});
    wr(ADDR_SPECIAL, 8'h00);
    wr(ADDR_SELECT_EN, 8'h12);
    send('{8'hc1}, 1'b0);
    check("select low", 8'h00, {7'h00, pin_out[1]});
    check("sdo enable", 8'h00, {7'h00, sdo_oe});
    m.xbyte(8'h40, r);
    m.xbyte(8'h77, r);
    m.xbyte(8'h00, r);
    m.stop();
    check("select high", 8'h01, {7'h00, pin_out[1]});
    check("gain held", 8'h11, gain_setting);
    send('{8'hc4}, 1'b1);
    check("input pin", 8'h00, {7'h00, pin_oe[4]});
    wr(ADDR_SPECIAL, 8'h38);
    st = starts;
    pin_in[4] = 1'b1;
    buffer_busy = 1'b1;
    m.tick(12);
    check("pin start count", 8'(st + 1), 8'(starts));
    check("pin hold", 8'h01, {7'h00, buffer_pin_hold});
    check("busy pin", 8'h01, {7'h00, pin_out[5]});
    pin_in[4] = 1'b0;
    buffer_busy = 1'b0;
    error_sources = 8'h01;
    m.tick(4);
    check("error pin", 8'h01, {7'h00, pin_out[3]});
    error_sources = 8'h00;
    ref_regs[ADDR_ERROR_FLAGS] = 8'h09;
    rd(ADDR_ERROR_FLAGS);
    wr(ADDR_ERROR_FLAGS, 8'hff);
    ref_regs[ADDR_ERROR_FLAGS] = 8'h00;
    rd(ADDR_ERROR_FLAGS);
    wr(ADDR_PORT_CONFIG, 8'h01);
    send('{8'h40, 8'h33, 8'h00}, 1'b1);
    check("bad sum gain", 8'h11, gain_setting);
    s1 = 8'(CHECKSUM_SEED + 8'h40 + 8'h21);
    s2 = 8'(s1 + 8'h40 + 8'h22);
    send('{8'h40, 8'h21, s1, 8'h40, 8'h22, s2}, 1'b1);
    check("chain gain", 8'h22, gain_setting);
    send('{8'h40, 8'h55}, 1'b0);
    check("early gain", 8'h22, gain_setting);
    m.xbyte(8'(CHECKSUM_SEED + 8'h40 + 8'h55), r);
    m.stop();
    check("late gain", 8'h55, gain_setting);
    send('{8'hc1, 8'(CHECKSUM_SEED + 8'hc1)}, 1'b0);
    check("summed select", 8'h00, {7'h00, pin_out[1]});
    m.stop();
    check("summed release", 8'h01, {7'h00, pin_out[1]});
    ref_regs[ADDR_GAIN] = 8'h55;
    ref_regs[ADDR_ERROR_FLAGS] = 8'h80;
    rd(ADDR_ERROR_FLAGS);
    send('{8'h41, 8'h01, 8'hdd}, 1'b1);
    clear_ref();
    rd(ADDR_PORT_CONFIG);
    rd(ADDR_GAIN);
    conclude();
  end
endmodule // tb_spi_command_port_checksum_ecs
